// File: design/tpo_pkg.sv
// shared constants for the timer and prescaler option register
package tpo_pkg;
	localparam int unsigned OPT_W = 8;
	localparam int unsigned WAKE_BIT = 7;
	localparam int unsigned PULLUP_BIT = 6;
	localparam int unsigned SRC_BIT = 5;
	localparam int unsigned EDGE_BIT = 4;
	localparam int unsigned ASSIGN_BIT = 3;
	localparam int unsigned RATIO_MSB = 2;
	localparam int unsigned RATIO_LSB = 0;
	localparam int unsigned RATIO_W = 3;
	localparam int unsigned LOG2_W = 4;
	localparam logic [7:0] OPT_RESET = 8'hFF;
	localparam logic [3:0] LOG2_BYPASS = 4'h0;
	localparam logic [3:0] TMR_LOG2_RESET = 4'h0;
	localparam logic [3:0] WDT_LOG2_RESET = 4'h7;
	localparam int unsigned PIN_COUNT = 4;
	localparam int unsigned PIN_COUNT_MAX = 8;
endpackage

// File: design/tpo_src_if.sv
// carrier between the option register and its timer clock source
`timescale 1ns/1ns
`default_nettype none
interface tpo_src_if;
	logic ext_sel;
	logic fall_sel;
	logic tick;
	modport core (output ext_sel, output fall_sel, input tick);
	modport src (input ext_sel, input fall_sel, output tick);
endinterface
`default_nettype wire

// File: design/tpo_timer_source.sv
// timer0 increment source: pin edge or instruction cycle tick
`timescale 1ns/1ns
`default_nettype none
module tpo_timer_source import tpo_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_pin,
	input wire logic i_instr_tick,
	tpo_src_if.src bus
);
	typedef struct packed {
		logic pin_prev;
		logic tick;
	} tpo_src_state_type;

	tpo_src_state_type s_q, s_d;
	logic rise, fall;

	always_comb begin
		s_d = s_q;
		rise = !s_q.pin_prev && i_pin;
		fall = s_q.pin_prev && !i_pin;
		if (i_ce) begin
			s_d.pin_prev = i_pin;
			if (bus.ext_sel) begin // (R5)
				s_d.tick = bus.fall_sel ? fall : rise; // (R6)
			end else begin
				s_d.tick = i_instr_tick; // (R5)
			end
		end
	end

	// pin idles high after reset, so a low pin then counts as a fall
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '{pin_prev: 1'b1, tick: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.tick = s_q.tick;

	fall_edge_a: assert property ( // (R6)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && bus.ext_sel && bus.fall_sel && s_q.pin_prev && !i_pin
		|=> bus.tick)
		else $error("falling edge not counted");
	rise_edge_a: assert property ( // (R6)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && bus.ext_sel && !bus.fall_sel && s_q.pin_prev
		|=> !bus.tick)
		else $error("tick without rising edge");
	rise_count_a: assert property ( // (R6)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && bus.ext_sel && !bus.fall_sel && !s_q.pin_prev && i_pin
		|=> bus.tick)
		else $error("rising edge not counted");
endmodule // tpo_timer_source
`default_nettype wire

// File: design/tpo_option_reg.sv
// timer and prescaler option register with pin override logic
// Operation
// (R1) the option register is eight bits and cannot be read back.
// (R2) the load instruction copies the whole working register into it.
// (R3) any reset sets all eight option bits to one.
// (R4) an output-direction pin loses wake-on-change and weak pull-up.
// (R5) source bit one: count the clock pin and force it input.
// (R6) edge bit one counts falling pin edges, zero counts rising.
// (R7) bit 3 gives prescaler to watchdog; bits 2..0 pick ratio.
// (R8) bits 7 and 6 enable wake and pull-ups when zero, all pins.
`timescale 1ns/1ns
`default_nettype none
module tpo_option_reg import tpo_pkg::*; #(
	parameter int unsigned NPINS = PIN_COUNT
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_option_load,
	input wire logic [7:0] i_work_data,
	input wire logic [NPINS-1:0] i_pin_direction_bits,
	input wire logic i_timer_pin_direction,
	input wire logic i_timer_external_clock_pin,
	input wire logic i_instr_cycle_tick,
	output logic [NPINS-1:0] o_pin_change_wake_en,
	output logic [NPINS-1:0] o_weak_pullup_en,
	output logic o_timer_pin_direction,
	output logic o_timer_external_select,
	output logic o_timer_increment,
	output logic o_prescaler_assign_select,
	output logic [3:0] o_timer_ratio_log2,
	output logic [3:0] o_watchdog_ratio_log2
);
	// ======================================================
	// parameter check, refused at elaboration
	if (NPINS < 1 || NPINS > PIN_COUNT_MAX) begin : g_bad_npins
		$error("NPINS out of range");
	end

	// ======================================================
	// state
	typedef struct packed {
		logic [7:0] option;
		logic [NPINS-1:0] wake_en;
		logic [NPINS-1:0] pullup_en;
		logic tmr_dir;
		logic [3:0] tmr_log2;
		logic [3:0] wdt_log2;
	} tpo_state_type;

	tpo_state_type s_q, s_d;
	tpo_src_if src_bus ();

	logic [NPINS-1:0] wake_gate;
	logic [NPINS-1:0] pullup_gate;
	logic [RATIO_W-1:0] ratio;
	logic wake_disable, pullup_disable;

	assign wake_disable = s_q.option[WAKE_BIT];
	assign pullup_disable = s_q.option[PULLUP_BIT];
	assign ratio = s_q.option[RATIO_MSB:RATIO_LSB];

	// ======================================================
	// per pin enables
	// direction zero means the pin drives, so its input aids stay off
	for (genvar p = 0; p < NPINS; p++) begin : g_pin
		assign wake_gate[p] = i_pin_direction_bits[p]
			&& !wake_disable; // (R4) (R8)
		assign pullup_gate[p] = i_pin_direction_bits[p]
			&& !pullup_disable; // (R4) (R8)
	end

	// ======================================================
	// next state
	always_comb begin
		s_d = s_q;
		if (i_ce) begin
			if (i_option_load) begin
				s_d.option = i_work_data; // (R2)
			end
			s_d.wake_en = wake_gate;
			s_d.pullup_en = pullup_gate;
			// external source overrides the pin's own direction bit
			s_d.tmr_dir = s_q.option[SRC_BIT]
				|| i_timer_pin_direction; // (R5)
			if (s_q.option[ASSIGN_BIT]) begin // (R7)
				s_d.tmr_log2 = LOG2_BYPASS;
				s_d.wdt_log2 = {1'b0, ratio};
			end else begin
				s_d.tmr_log2 = 4'({1'b0, ratio} + 4'h1);
				s_d.wdt_log2 = LOG2_BYPASS;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q.option <= OPT_RESET; // (R3)
			s_q.wake_en <= '0;
			s_q.pullup_en <= '0;
			s_q.tmr_dir <= 1'b1;
			s_q.tmr_log2 <= TMR_LOG2_RESET;
			s_q.wdt_log2 <= WDT_LOG2_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ======================================================
	// timer source
	assign src_bus.ext_sel = s_q.option[SRC_BIT]; // (R5)
	assign src_bus.fall_sel = s_q.option[EDGE_BIT]; // (R6)

	tpo_timer_source u_src (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_pin(i_timer_external_clock_pin),
		.i_instr_tick(i_instr_cycle_tick),
		.bus(src_bus.src)
	);

	// ======================================================
	// outputs; the option byte itself has no read path
	assign o_pin_change_wake_en = s_q.wake_en; // (R1)
	assign o_weak_pullup_en = s_q.pullup_en;
	assign o_timer_pin_direction = s_q.tmr_dir;
	assign o_timer_external_select = s_q.option[SRC_BIT];
	assign o_timer_increment = src_bus.tick;
	assign o_prescaler_assign_select = s_q.option[ASSIGN_BIT];
	assign o_timer_ratio_log2 = s_q.tmr_log2;
	assign o_watchdog_ratio_log2 = s_q.wdt_log2;

	// ======================================================
	// checks
	// a level on the strobe reloads every enabled cycle; the core pulses it
	load_copies_a: assert property ( // (R2)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && i_option_load |=> s_q.option == $past(i_work_data))
		else $error("option load did not copy working data");

	option_holds_a: assert property ( // (R1)
		@(posedge i_mclk) disable iff (!i_rst_n)
		!(i_ce && i_option_load) |=> $stable(s_q.option))
		else $error("option changed without load");

	ce_freeze_a: assert property ( // (R2)
		@(posedge i_mclk) disable iff (!i_rst_n)
		!i_ce |=> $stable(s_q))
		else $error("state moved while clock enable low");

	reset_all_ones_a: assert property ( // (R3)
		@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> s_q.option == OPT_RESET)
		else $error("option not all ones after reset");

	output_pin_off_a: assert property ( // (R4)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce |=> ((o_pin_change_wake_en | o_weak_pullup_en)
			& ~$past(i_pin_direction_bits)) == '0)
		else $error("output pin kept wake or pull-up");

	wake_enable_a: assert property ( // (R8)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce |=> o_pin_change_wake_en == ($past(i_pin_direction_bits)
			& {NPINS{!$past(wake_disable)}}))
		else $error("wake enable wrong");

	pullup_enable_a: assert property ( // (R8)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && !pullup_disable && i_pin_direction_bits[0]
		|=> o_weak_pullup_en[0])
		else $error("pull-up not enabled");

	pullup_off_a: assert property ( // (R8)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && pullup_disable |=> o_weak_pullup_en == '0)
		else $error("pull-up on while disabled");

	ext_select_a: assert property ( // (R5)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && i_option_load && i_work_data[SRC_BIT]
		|=> o_timer_external_select)
		else $error("external timer clock not selected");

	assign_timer_a: assert property ( // (R7)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && i_option_load && !i_work_data[ASSIGN_BIT]
		|=> !o_prescaler_assign_select)
		else $error("prescaler not given to timer");

	src_force_a: assert property ( // (R5)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && s_q.option[SRC_BIT] |=> o_timer_pin_direction)
		else $error("timer pin not forced to input");

	dir_follows_a: assert property ( // (R5)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && !s_q.option[SRC_BIT]
		|=> o_timer_pin_direction == $past(i_timer_pin_direction))
		else $error("timer pin direction not passed");

	internal_tick_a: assert property ( // (R5)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && !s_q.option[SRC_BIT]
		|=> o_timer_increment == $past(i_instr_cycle_tick))
		else $error("internal tick not passed");

	// one code divides the timer one step coarser than the watchdog
	ratio_decode_a: assert property ( // (R7)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && !s_q.option[ASSIGN_BIT]
		|=> o_timer_ratio_log2 == 4'({1'b0, $past(ratio)} + 4'h1)
			&& o_watchdog_ratio_log2 == LOG2_BYPASS)
		else $error("timer prescale ratio wrong");

	wdt_ratio_a: assert property ( // (R7)
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && s_q.option[ASSIGN_BIT]
		|=> o_watchdog_ratio_log2 == {1'b0, $past(ratio)}
			&& o_timer_ratio_log2 == LOG2_BYPASS)
		else $error("watchdog prescale ratio wrong");
endmodule // tpo_option_reg
`default_nettype wire

// File: tb/tpo_core_model.sv
// behavioural processor core issuing option load instructions
`timescale 1ns/1ns
`default_nettype none
module tpo_core_model (
	input wire logic i_mclk,
	output logic o_option_load,
	output logic [7:0] o_work_data
);
	initial begin
		o_option_load = 1'b0;
		o_work_data = 8'h00;
	end
	// ==========================================
	// load instruction: one strobe cycle
	task automatic load(input logic [7:0] w);
		@(posedge i_mclk) #2;
		o_option_load = 1'b1;
		o_work_data = w;
		@(posedge i_mclk) #2;
		o_option_load = 1'b0;
		// inverse after release so a stale byte never matches
		o_work_data = ~w;
	endtask
endmodule // tpo_core_model
`default_nettype wire

// File: tb/tpo_option_reg_tb_top.sv
// self-checking bench for the timer option register
`timescale 1ns/1ns
`default_nettype none
module tpo_option_reg_tb_top;
	import tpo_pkg::*;
	localparam int unsigned NP = 6;
	logic i_mclk, i_rst_n, i_ce, ld, tdir, pin, tick, odir, oext, oinc, oasg;
	logic [7:0] wdata;
	logic [NP-1:0] dirs, wake, pull, mdirs;
	logic mtdir;
	logic [3:0] tlog, wlog;
	int failures = 0;
	int num_checks = 0;
	int opt, lastpin, pv, expinc;
	tpo_core_model core_u (.i_mclk(i_mclk), .o_option_load(ld),
		.o_work_data(wdata));
	tpo_option_reg #(.NPINS(NP)) dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_ce(i_ce), .i_option_load(ld), .i_work_data(wdata),
		.i_pin_direction_bits(dirs), .i_timer_pin_direction(tdir),
		.i_timer_external_clock_pin(pin), .i_instr_cycle_tick(tick),
		.o_pin_change_wake_en(wake), .o_weak_pullup_en(pull),
		.o_timer_pin_direction(odir), .o_timer_external_select(oext),
		.o_timer_increment(oinc), .o_prescaler_assign_select(oasg),
		.o_timer_ratio_log2(tlog), .o_watchdog_ratio_log2(wlog));
	// ==========================================
	// checking and model
	task automatic chk(input string nm, input logic [7:0] got,
		input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_out();
		logic [7:0] o;
		o = opt[7:0];
		chk("ext", 8'(oext), 8'(o[SRC_BIT]));
		chk("asg", 8'(oasg), 8'(o[ASSIGN_BIT]));
		chk("wake", 8'(wake), o[WAKE_BIT] ? 8'h00 : 8'(mdirs));
		chk("pull", 8'(pull), o[PULLUP_BIT] ? 8'h00 : 8'(mdirs));
		chk("dir", 8'(odir), 8'(o[SRC_BIT] | mtdir));
		chk("tlog", 8'(tlog), o[ASSIGN_BIT] ? 8'h00 : 8'(o[2:0]) + 8'h01);
		chk("wlog", 8'(wlog), o[ASSIGN_BIT] ? 8'(o[2:0]) : 8'h00);
	endtask
	task automatic do_reset();
		i_rst_n = 1'b0;
		opt = 8'hFF;
		repeat (10) @(posedge i_mclk);
		#1;
		chk_out();
		#1 i_rst_n = 1'b1;
		@(posedge i_mclk) #1;
		chk_out();
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	initial begin
		#100000;
		failures++;
		give_verdict();
	end
	// ==========================================
	// main sequence
	initial begin
		logic [7:0] w;
		i_ce = 1'b1;
		tdir = 1'b0;
		pin = 1'b1;
		tick = 1'b0;
		dirs = '0;
		mdirs = '0;
		mtdir = 1'b0;
		lastpin = 1;
		expinc = 0;
		w = 8'($urandom(32'h19E4));
		do_reset();
		for (int i = 0; i < 40; i++) begin
			@(posedge i_mclk) #2;
			w = 8'($urandom);
			w[3:0] = 4'(i);
			i_ce = (i % 5 != 4);
			dirs = NP'($urandom);
			tdir = 1'($urandom);
			// while ce is low the outputs must keep the old directions
			if (i_ce) begin
				mdirs = dirs;
				mtdir = tdir;
				opt = w;
			end
			core_u.load(w);
			@(posedge i_mclk) #1;
			chk_out();
		end
		// the last pass leaves ce low; the edge scenarios need it running
		@(posedge i_mclk) #2;
		i_ce = 1'b1;
		for (int k = 0; k < 4; k++) begin
			w = 8'(k << 4);
			opt = w;
			core_u.load(w);
			repeat (30) begin
				@(posedge i_mclk) #1;
				chk("inc", 8'(oinc), 8'(expinc));
				#1;
				pv = $urandom & 1;
				pin = 1'(pv);
				tick = 1'($urandom);
				if (opt[SRC_BIT])
					expinc = opt[EDGE_BIT] ? lastpin & ~pv : ~lastpin & pv;
				else
					expinc = tick;
				lastpin = pv;
			end
			@(posedge i_mclk) #1;
			chk("inc", 8'(oinc), 8'(expinc));
			#1;
			tick = 1'b0;
			expinc = 0;
		end
		do_reset();
		give_verdict();
	end
endmodule // tpo_option_reg_tb_top
`default_nettype wire
